/* File: src/ofdm_loop_ctrl.sv */
// Loop control register bank with sweep, AGC and clock loop datapath
`timescale 1ns/10ps
`default_nettype none
// Function
// - Clock byte: high proportional, low integrator
// - Nibbles are signed exponents of two
// - Integrator byte: high gain, low freq
// - Integrator nibbles adjust defaults, reset zero
// - Sweep starts from programmed start value
// - Exit threshold, low fifteen bits compared, ends coarse sweep
// - Gain loop compares level against threshold
// - Sweep advances by programmed step
// - Four soft-decision bytes, noise-optimal reset
// - Gain override drives twelve-bit output
// - Gain slope bit inverts output mapping
// - Frequency position readable, low byte first
// - Gain position readable, twelve bits signed
// - Oscillator override twelve-bit, top bits zero
// - Oscillator slope bit inverts output mapping
// - Fine timing enable lets loop drive oscillator
// - Write zero-one-zero restarts loops, keeps registers
module ofdm_loop_ctrl
    import loop_regs_pkg::*;
#(
    parameter int POS_W = 16
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    input wire logic [11:0] level_in,
    input wire logic signed [11:0] timing_err,
    input wire logic signed [15:0] freq_err,
    output logic signed [DAC_W-1:0] gain_dac,
    output logic signed [DAC_W-1:0] osc_dac,
    output logic [WORD_W-1:0] freq_offset,
    output logic coarse_active,
    output logic [31:0] soft_decision_cfg
);
    if (POS_W != WORD_W) begin : g_pos_check
        $error("POS_W must equal WORD_W");
    end

    // ***************************
    // State
    // ***************************
    typedef struct packed {
        logic [7:0] clk_loop;
        logic [7:0] int_gain;
        logic [15:0] sweep_start;
        logic [15:0] exit_thr;
        logic [7:0] gain_level;
        logic [15:0] sweep_step;
        logic [31:0] soft_dec;
        logic [7:0] mode2;
        logic [7:0] int_config;
        logic [15:0] gain_ovr;
        logic [15:0] osc_ovr;
        logic [7:0] low_hold;
        soft_reset_e sr_state;
        loop_phase_e phase;
        logic coarse;
        logic [15:0] freq_acc;
        logic signed [15:0] gain_acc;
        logic signed [15:0] clk_acc;
        logic [7:0] rdata;
        logic signed [11:0] gain_dac;
        logic signed [11:0] osc_dac;
        logic [31:0] soft_out;
    } state_s;

    state_s r;
    state_s next_r;

    logic signed [15:0] clk_prop;
    logic signed [15:0] clk_int;
    logic signed [15:0] gain_step;
    logic signed [15:0] freq_step;
    logic signed [15:0] gain_err;
    logic signed [15:0] terr_w;

    assign terr_w = 16'(timing_err);
    assign gain_err = $signed({8'h00, level_in[11:4]})
        - $signed({8'h00, r.gain_level});

    // Clock loop: proportional and integrator gains from one byte
    exp_gain #(.W(16)) u_clk_prop (
        .din(terr_w),
        .expo(r.clk_loop[7:4]),
        .konst(2'd1),
        .dout(clk_prop)
    );
    exp_gain #(.W(16)) u_clk_int (
        .din(terr_w),
        .expo(r.clk_loop[3:0]),
        .konst(2'd0),
        .dout(clk_int)
    );
    // Integrator nibbles offset a built-in default exponent of zero
    exp_gain #(.W(16)) u_gain_int (
        .din(gain_err),
        .expo(r.int_gain[7:4]),
        .konst(2'd0),
        .dout(gain_step)
    );
    exp_gain #(.W(16)) u_freq_int (
        .din(freq_err),
        .expo(r.int_gain[3:0]),
        .konst(2'd0),
        .dout(freq_step)
    );

    function automatic logic signed [11:0] slope(
        input logic signed [11:0] v,
        input logic inv
    );
        // Inversion by one's complement maps -2048 onto +2047 exactly
        slope = inv ? ~v : v;
    endfunction : slope

    // ***************************
    // Next state
    // ***************************
    always_comb begin
        logic restart;
        logic [7:0] a;
        logic signed [15:0] csum;
        restart = 1'b0;
        a = addr;
        csum = 16'sh0000;
        next_r = r;
        next_r.rdata = 8'h00;

        // Register writes; low bytes wait in a hold until the high byte
        if (wr) begin
            if (a == A_CLK_LOOP) begin
                next_r.clk_loop = wdata;
            end else if (a == A_INT_GAIN) begin
                next_r.int_gain = wdata;
            end else if (a == A_SWEEP_START_HI) begin
                next_r.sweep_start = {wdata, r.low_hold};
            end else if (a == A_EXIT_THR_HI) begin
                next_r.exit_thr = {wdata, r.low_hold};
            end else if (a == A_GAIN_LEVEL) begin
                next_r.gain_level = wdata;
            end else if (a == A_SWEEP_STEP_HI) begin
                next_r.sweep_step = {wdata, r.low_hold};
            end else if (a >= A_SOFT_DEC0 && a <= A_SOFT_DEC3) begin
                next_r.soft_dec[8*(a-A_SOFT_DEC0)+:8] = wdata;
            end else if (a == A_MODE2) begin
                next_r.mode2 = wdata;
            end else if (a == A_INT_CONFIG) begin
                next_r.int_config = wdata;
            end else if (a == A_GAIN_OVR_HI) begin
                next_r.gain_ovr = {4'h0, wdata[3:0], r.low_hold};
            end else if (a == A_OSC_OVR_HI) begin
                next_r.osc_ovr = {4'h0, wdata[3:0], r.low_hold};
            end else if (a == A_SOFT_RESET) begin
                case (r.sr_state)
                    SR_IDLE: begin
                        if (wdata == 8'h00) next_r.sr_state = SR_ZERO;
                    end
                    SR_ZERO: begin
                        if (wdata != 8'h00) next_r.sr_state = SR_ONE;
                    end
                    SR_ONE: begin
                        restart = (wdata == 8'h00);
                        next_r.sr_state = restart ? SR_ZERO : SR_IDLE;
                    end
                    default: begin
                        next_r.sr_state = SR_IDLE;
                    end
                endcase
            end
            if (a == A_SWEEP_START_LO || a == A_EXIT_THR_LO
                || a == A_SWEEP_STEP_LO || a == A_GAIN_OVR_LO
                || a == A_OSC_OVR_LO) begin
                next_r.low_hold = wdata;
            end
        end

        // Register reads; write-only and unmapped addresses read zero
        if (rd) begin
            if (a == A_CLK_LOOP) begin
                next_r.rdata = r.clk_loop;
            end else if (a == A_INT_GAIN) begin
                next_r.rdata = r.int_gain;
            end else if (a == A_SWEEP_START_LO) begin
                next_r.rdata = r.sweep_start[7:0];
            end else if (a == A_SWEEP_START_HI) begin
                next_r.rdata = r.sweep_start[15:8];
            end else if (a == A_EXIT_THR_LO) begin
                next_r.rdata = r.exit_thr[7:0];
            end else if (a == A_EXIT_THR_HI) begin
                next_r.rdata = r.exit_thr[15:8];
            end else if (a == A_GAIN_LEVEL) begin
                next_r.rdata = r.gain_level;
            end else if (a == A_SWEEP_STEP_LO) begin
                next_r.rdata = r.sweep_step[7:0];
            end else if (a == A_SWEEP_STEP_HI) begin
                next_r.rdata = r.sweep_step[15:8];
            end else if (a >= A_SOFT_DEC0 && a <= A_SOFT_DEC3) begin
                next_r.rdata = r.soft_dec[8*(a-A_SOFT_DEC0)+:8];
            end else if (a == A_FREQ_POS_LO) begin
                next_r.rdata = r.freq_acc[7:0];
            end else if (a == A_FREQ_POS_HI) begin
                next_r.rdata = r.freq_acc[15:8];
            end else if (a == A_GAIN_POS_LO) begin
                next_r.rdata = r.gain_dac[7:0];
            end else if (a == A_GAIN_POS_HI) begin
                next_r.rdata = {4'h0, r.gain_dac[11:8]};
            end
        end

        // Loops: coarse sweep, then pilot tracking
        case (r.phase)
            LP_SWEEP: begin
                next_r.freq_acc = 16'(r.freq_acc + r.sweep_step);
                if ((freq_err < 0 ? -freq_err : freq_err)
                    < $signed({1'b0, r.exit_thr[14:0]})) begin
                    next_r.phase = LP_TRACK;
                end
            end
            LP_TRACK: begin
                next_r.freq_acc = 16'(r.freq_acc + freq_step);
            end
            default: begin
                next_r.phase = LP_SWEEP;
            end
        endcase
        next_r.gain_acc = 16'(r.gain_acc - gain_step);
        next_r.clk_acc = 16'(r.clk_acc + clk_int);
        csum = 16'(r.clk_acc + clk_prop);

        if (restart) begin
            next_r.phase = LP_SWEEP;
            next_r.freq_acc = r.sweep_start;
            next_r.gain_acc = 16'sh0000;
            next_r.clk_acc = 16'sh0000;
        end

        next_r.coarse = (next_r.phase == LP_SWEEP);
        // Converter sources
        if (r.int_config == GAIN_OVR_KEY) begin
            next_r.gain_dac = slope(r.gain_ovr[11:0],
                r.mode2[GAIN_SLOPE_BIT]);
        end else begin
            next_r.gain_dac = slope(r.gain_acc[15:4],
                r.mode2[GAIN_SLOPE_BIT]);
        end
        if (r.mode2[FINE_TIMING_BIT]) begin
            next_r.osc_dac = slope(csum[15:4],
                r.mode2[OSC_SLOPE_BIT]);
        end else begin
            next_r.osc_dac = slope(r.osc_ovr[11:0],
                r.mode2[OSC_SLOPE_BIT]);
        end
        next_r.soft_out = r.soft_dec;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            r <= '{clk_loop: CLK_LOOP_RESET, int_gain: INT_GAIN_RESET,
                sweep_start: SWEEP_START_RESET, exit_thr: EXIT_THR_RESET,
                gain_level: GAIN_LEVEL_RESET, sweep_step: SWEEP_STEP_RESET,
                soft_dec: SOFT_DEC_RESET, mode2: MODE2_RESET,
                sr_state: SR_IDLE, phase: LP_SWEEP, coarse: 1'b1,
                freq_acc: SWEEP_START_RESET, soft_out: SOFT_DEC_RESET,
                default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign rdata = r.rdata;
    assign gain_dac = r.gain_dac;
    assign osc_dac = r.osc_dac;
    assign freq_offset = r.freq_acc;
    assign coarse_active = r.coarse;
    assign soft_decision_cfg = r.soft_out;

    // ***************************
    // Checks
    // ***************************
    gain_ovr_map_a: assert property (@(posedge mclk)
        disable iff (!rstn)
        (r.int_config == GAIN_OVR_KEY && !r.mode2[GAIN_SLOPE_BIT]
         && $stable(r.gain_ovr) && $stable(r.int_config))
        |=> gain_dac == $past(r.gain_ovr[11:0]))
        else $error("gain override not applied");
    gain_slope_inv_a: assert property (@(posedge mclk)
        disable iff (!rstn)
        (r.int_config == GAIN_OVR_KEY && r.mode2[GAIN_SLOPE_BIT])
        |=> gain_dac == ~$past(r.gain_ovr[11:0]))
        else $error("gain slope not inverted");
    osc_ovr_map_a: assert property (@(posedge mclk)
        disable iff (!rstn)
        (!r.mode2[FINE_TIMING_BIT])
        |=> osc_dac == ($past(r.mode2[OSC_SLOPE_BIT])
            ? ~$past(r.osc_ovr[11:0]) : $past(r.osc_ovr[11:0])))
        else $error("oscillator override mapping wrong");
    osc_top_zero_a: assert property (@(posedge mclk)
        disable iff (!rstn)
        (wr && addr == A_OSC_OVR_HI)
        |=> r.osc_ovr == {4'h0, $past(wdata[3:0]), $past(r.low_hold)})
        else $error("override top bits not zero");
    gain_pos_rd_a: assert property (@(posedge mclk)
        disable iff (!rstn)
        (rd && addr == A_GAIN_POS_HI) |=> rdata[7:4] == 4'h0)
        else $error("gain position top bits not zero");
    gain_pos_lo_a: assert property (@(posedge mclk)
        disable iff (!rstn)
        (rd && addr == A_GAIN_POS_LO) |=> rdata == $past(gain_dac[7:0]))
        else $error("gain position low byte wrong");
    freq_pos_rd_a: assert property (@(posedge mclk)
        disable iff (!rstn)
        (rd && addr == A_FREQ_POS_LO) |=> rdata == $past(r.freq_acc[7:0]))
        else $error("frequency position low byte wrong");
    sweep_restart_a: assert property (@(posedge mclk)
        disable iff (!rstn)
        (wr && addr == A_SOFT_RESET && wdata == 8'h00
         && r.sr_state == SR_ONE)
        |=> freq_offset == $past(r.sweep_start) && coarse_active)
        else $error("sweep not restarted from start value");
    sweep_step_a: assert property (@(posedge mclk)
        disable iff (!rstn)
        (coarse_active && !(wr && addr == A_SOFT_RESET))
        |=> freq_offset == 16'($past(r.freq_acc) + $past(r.sweep_step)))
        else $error("sweep step wrong");
    coarse_stay_a: assert property (@(posedge mclk)
        disable iff (!rstn)
        (!coarse_active && !(wr && addr == A_SOFT_RESET)) |=> !coarse_active)
        else $error("coarse sweep resumed without restart");
    word_whole_a: assert property (@(posedge mclk)
        disable iff (!rstn)
        (wr && addr == A_SWEEP_STEP_LO) |=> $stable(r.sweep_step))
        else $error("partial word took effect");
    keep_regs_a: assert property (@(posedge mclk)
        disable iff (!rstn)
        (wr && addr == A_SOFT_RESET) |=> $stable(r.gain_level)
        && $stable(r.soft_dec))
        else $error("soft reset changed a register");
endmodule : ofdm_loop_ctrl
`default_nettype wire

/* File: inc/loop_regs_pkg.sv */
// Register map, field layout and reset values of the loop control bank
package loop_regs_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int WORD_W = 16;
    localparam int DAC_W = 12;

    // Register offsets
    localparam logic [7:0] A_CLK_LOOP = 8'h0e;
    localparam logic [7:0] A_INT_GAIN = 8'h0f;
    localparam logic [7:0] A_SWEEP_START_LO = 8'h10;
    localparam logic [7:0] A_SWEEP_START_HI = 8'h11;
    localparam logic [7:0] A_EXIT_THR_LO = 8'h12;
    localparam logic [7:0] A_EXIT_THR_HI = 8'h13;
    localparam logic [7:0] A_GAIN_LEVEL = 8'h14;
    localparam logic [7:0] A_SWEEP_STEP_LO = 8'h15;
    localparam logic [7:0] A_SWEEP_STEP_HI = 8'h16;
    localparam logic [7:0] A_SOFT_DEC0 = 8'h17;
    localparam logic [7:0] A_SOFT_DEC3 = 8'h1a;
    localparam logic [7:0] A_INT_CONFIG = 8'h21;
    localparam logic [7:0] A_GAIN_OVR_LO = 8'h25;
    localparam logic [7:0] A_GAIN_OVR_HI = 8'h26;
    localparam logic [7:0] A_FREQ_POS_LO = 8'h2f;
    localparam logic [7:0] A_FREQ_POS_HI = 8'h30;
    localparam logic [7:0] A_GAIN_POS_LO = 8'h33;
    localparam logic [7:0] A_GAIN_POS_HI = 8'h34;
    localparam logic [7:0] A_OSC_OVR_LO = 8'h36;
    localparam logic [7:0] A_OSC_OVR_HI = 8'h37;
    // Neighbouring control registers of the same block
    localparam logic [7:0] A_SOFT_RESET = 8'h0a;
    localparam logic [7:0] A_MODE2 = 8'h0d;

    // Mode register 2 fields
    localparam int FINE_TIMING_BIT = 7;
    localparam int GAIN_SLOPE_BIT = 5;
    localparam int OSC_SLOPE_BIT = 0;
    localparam logic [7:0] MODE2_RESET = 8'h31;

    localparam logic [7:0] GAIN_OVR_KEY = 8'hba;
    localparam logic [7:0] INT_GAIN_RESET = 8'h00;
    localparam logic [7:0] GAIN_LEVEL_RESET = 8'h40;
    localparam logic [15:0] SWEEP_START_RESET = 16'h0000;
    localparam logic [15:0] SWEEP_STEP_RESET = 16'h0010;
    localparam logic [15:0] EXIT_THR_RESET = 16'h0800;
    localparam logic [31:0] SOFT_DEC_RESET = 32'h20_10_08_04;
    localparam logic [7:0] CLK_LOOP_RESET = 8'h00;

    typedef enum logic [1:0] {
        SR_IDLE = 2'b00,
        SR_ZERO = 2'b01,
        SR_ONE = 2'b10
    } soft_reset_e;

    typedef enum logic [1:0] {
        LP_SWEEP = 2'b00,
        LP_TRACK = 2'b01
    } loop_phase_e;

endpackage : loop_regs_pkg

/* File: src/exp_gain.sv */
// Signed-exponent gain stage: value scaled by (c + 2^n), n a signed nibble
`timescale 1ns/10ps
`default_nettype none
module exp_gain
    import loop_regs_pkg::*;
#(
    parameter int W = 16
) (
    input wire logic signed [W-1:0] din,
    input wire logic signed [3:0] expo,
    input wire logic [1:0] konst,
    output logic signed [W-1:0] dout
);
    if (W < 9) begin : g_width_check
        $error("exp_gain width too small");
    end

    logic signed [W-1:0] shifted;
    logic [3:0] mag;

    // Four bits so that an exponent of -8 shifts by eight, not zero
    always_comb begin
        mag = expo[3] ? 4'(-expo) : {1'b0, expo[2:0]};
        shifted = expo[3] ? (din >>> mag) : W'(din <<< mag);
        dout = W'(shifted + din * $signed({1'b0, konst}));
    end
endmodule : exp_gain
`default_nettype wire

/* File: tb/tuner_model.sv */
// Tuner front end model that feeds level, timing and frequency errors
`timescale 1ns/10ps
`default_nettype none
module tuner_model
    import loop_regs_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic signed [DAC_W-1:0] gain_dac,
    input wire logic signed [DAC_W-1:0] osc_dac,
    output logic [11:0] level_in,
    output logic signed [11:0] timing_err,
    output logic signed [15:0] freq_err
);
    logic flip;

    // Level follows the control word in offset binary, one cycle late
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            flip <= 1'b0;
            level_in <= 12'h800;
            timing_err <= 12'sh000;
        end else begin
            flip <= ~flip;
            level_in <= {~gain_dac[11], gain_dac[10:0]};
            timing_err <= osc_dac >>> 2;
        end
    end

    // Carrier sits far off and the sign alternates, so a magnitude
    // compare that ignores the sign shows up quickly
    assign freq_err = flip ? 16'sh4000 : 16'shc000;
endmodule : tuner_model
`default_nettype wire

/* File: tb/ofdm_loop_control_registers_tb_top.sv */
// Self-checking bench for the loop control register bank
`timescale 1ns/10ps
`default_nettype none
module ofdm_loop_control_registers_tb_top
    import loop_regs_pkg::*;
;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [11:0] level_in;
    logic signed [11:0] timing_err, gain_dac, osc_dac;
    logic signed [15:0] freq_err;
    logic [15:0] freq_offset;
    logic coarse_active;
    logic [31:0] soft_decision_cfg;
    int failures = 0;
    int comparisons = 0;
    int seed = 32'h729ddd26;
    logic [15:0] exp_q[$];
    logic [15:0] note;
    logic rd_seen = 1'b0;
    logic [103:0] rst_tab;
    logic [7:0] val[13];
    logic [15:0] start;
    logic [11:0] v, e;
    logic [7:0] m;

    always #10 mclk = ~mclk;

    ofdm_loop_ctrl #(.POS_W(16)) dut (
        .mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .level_in(level_in),
        .timing_err(timing_err), .freq_err(freq_err), .gain_dac(gain_dac),
        .osc_dac(osc_dac), .freq_offset(freq_offset),
        .coarse_active(coarse_active), .soft_decision_cfg(soft_decision_cfg)
    );

    tuner_model far (
        .mclk(mclk), .rstn(rstn), .gain_dac(gain_dac), .osc_dac(osc_dac),
        .level_in(level_in), .timing_err(timing_err), .freq_err(freq_err)
    );

    // ************************************************************
    // Bus tasks and comparison
    // ************************************************************
    task check(input string what, input logic [15:0] seen,
               input logic [15:0] expv);
        comparisons++;
        if (seen !== expv) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, expv, seen);
        end
    endtask : check

    task final_report;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    // Strobes stay up between calls so back-to-back cycles need no gap
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
        @(posedge mclk);
    endtask : wr_reg

    task rd_reg(input logic [7:0] a, input logic [7:0] x);
        addr <= a;
        rd <= 1'b1;
        wr <= 1'b0;
        exp_q.push_back({a, x});
        @(posedge mclk);
    endtask : rd_reg

    // Ends just past an edge so outputs have settled before sampling
    task idle(input int n);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge mclk);
        #1;
    endtask : idle

    // Read data stands only in the cycle after the strobe
    always @(posedge mclk) begin
        if (rd_seen) begin
            note = exp_q.pop_front();
            check($sformatf("read %h", note[15:8]), {8'h00, rdata},
                  {8'h00, note[7:0]});
        end
        rd_seen <= rd;
    end

    initial begin
        #200000;
        failures++;
        final_report();
    end

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        rst_tab = {SOFT_DEC_RESET, SWEEP_STEP_RESET, GAIN_LEVEL_RESET,
                   EXIT_THR_RESET, SWEEP_START_RESET, INT_GAIN_RESET,
                   CLK_LOOP_RESET};
        repeat (15) @(posedge mclk);
        #1;
        check("freq_offset", freq_offset, SWEEP_START_RESET);
        check("coarse_active", {15'h0, coarse_active}, 16'h0001);
        check("cfg lo", soft_decision_cfg[15:0], SOFT_DEC_RESET[15:0]);
        check("cfg hi", soft_decision_cfg[31:16],
              SOFT_DEC_RESET[31:16]);
        @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        for (int i = 0; i < 13; i++) begin
            rd_reg(8'h0e + 8'(i), rst_tab[8*i +: 8]);
        end
        idle(2);
        $display("test reset_values done");

        start = 16'($random(seed));
        wr_reg(A_SWEEP_START_LO, start[7:0]);
        wr_reg(A_SWEEP_START_HI, start[15:8]);
        wr_reg(A_SWEEP_STEP_LO, 8'h00);
        wr_reg(A_SWEEP_STEP_HI, 8'h01);
        wr_reg(A_SOFT_RESET, 8'h00);
        wr_reg(A_SOFT_RESET, 8'($random(seed)) | 8'h01);
        wr_reg(A_SOFT_RESET, 8'h00);
        // The start value stands for one cycle only, then the sweep steps
        wr <= 1'b0;
        #1;
        check("restart offset", freq_offset, start);
        check("restart coarse", {15'h0, coarse_active}, 16'h0001);
        // A step with a zero low byte must leave the low byte alone
        for (int i = 0; i < 16; i++) begin
            @(posedge mclk);
            #1;
            check("sweep lo", {8'h00, freq_offset[7:0]},
                  {8'h00, start[7:0]});
        end
        rd_reg(A_SWEEP_START_LO, start[7:0]);
        rd_reg(A_SWEEP_START_HI, start[15:8]);
        rd_reg(A_FREQ_POS_LO, start[7:0]);
        idle(2);
        $display("test soft_restart done");

        wr_reg(A_EXIT_THR_LO, 8'h01);
        idle(4);
        check("half threshold", {15'h0, coarse_active}, 16'h0001);
        wr_reg(A_EXIT_THR_HI, 8'h40);
        idle(4);
        check("sweep exit", {15'h0, coarse_active}, 16'h0000);
        $display("test exit_threshold done");

        for (int i = 0; i < 13; i++) begin
            val[i] = 8'($random(seed));
            wr_reg(8'h0e + 8'(i), val[i]);
        end
        wr_reg(8'h3f, 8'h5a);
        for (int i = 0; i < 13; i++) begin
            rd_reg(8'h0e + 8'(i), val[i]);
        end
        rd_reg(8'h3f, 8'h00);
        rd_reg(A_INT_CONFIG, 8'h00);
        rd_reg(A_GAIN_OVR_HI, 8'h00);
        rd_reg(A_OSC_OVR_LO, 8'h00);
        idle(2);
        check("cfg lo", soft_decision_cfg[15:0], {val[10], val[9]});
        check("cfg hi", soft_decision_cfg[31:16], {val[12], val[11]});
        $display("test register_access done");

        wr_reg(A_INT_CONFIG, GAIN_OVR_KEY);
        for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < 3; k++) begin
                v = (k == 0) ? 12'h800
                    : (k == 1) ? 12'h7ff : 12'($random(seed));
                m = MODE2_RESET;
                m[FINE_TIMING_BIT] = 1'b0;
                m[GAIN_SLOPE_BIT] = s[0];
                m[OSC_SLOPE_BIT] = s[0];
                wr_reg(A_MODE2, m);
                wr_reg(A_GAIN_OVR_LO, v[7:0]);
                wr_reg(A_GAIN_OVR_HI, {4'hf, v[11:8]});
                wr_reg(A_OSC_OVR_LO, v[7:0]);
                wr_reg(A_OSC_OVR_HI, {4'ha, v[11:8]});
                wr_reg(A_GAIN_POS_LO, 8'h55);
                e = s[0] ? ~v : v;
                idle(3);
                check("gain_dac", {4'h0, gain_dac}, {4'h0, e});
                check("osc_dac", {4'h0, osc_dac}, {4'h0, e});
                rd_reg(A_GAIN_POS_LO, e[7:0]);
                rd_reg(A_GAIN_POS_HI, {4'h0, e[11:8]});
                wr_reg(A_OSC_OVR_LO, ~v[7:0]);
                idle(3);
                check("osc half", {4'h0, osc_dac}, {4'h0, e});
            end
        end
        $display("test overrides done");
        final_report();
    end
endmodule : ofdm_loop_control_registers_tb_top
`default_nettype wire
